// ---- bcq_capture.sv ----
`timescale 1ns/1ps
module bcq_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = bcq_pkg::FIFO_DEPTH
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic         in_valid_i,
  output logic              in_ready_o,
  input  wire logic [W-1:0] in_data_i,
  output logic              out_valid_o,
  input  wire logic         out_ready_i,
  output logic [W-1:0]      out_data_o
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
    $error("bcq_fifo depth must be a power of two of at least 2");
  end

  logic [W-1:0] mem [DEPTH];
  logic [AW:0]  wr_ptr;
  logic [AW:0]  rd_ptr;
  logic [AW:0]  next_wr_ptr;
  logic [AW:0]  next_rd_ptr;
  logic         do_wr;
  logic         do_rd;
  logic         next_out_valid;
  logic [W-1:0] next_out_data;

  // Pointer step, shared by both ends
  function automatic logic [AW:0] bump(input logic [AW:0] p);
    return p + {{AW{1'b0}}, 1'b1};
  endfunction

  // Extra pointer bit tells full from empty
  assign in_ready_o = !((wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]));
  assign do_wr      = in_valid_i && in_ready_o;
  assign do_rd      = out_valid_o && out_ready_i;

  // Next pointers and the head word offered on the read side
  always_comb begin
    next_wr_ptr    = do_wr ? bump(wr_ptr) : wr_ptr;
    next_rd_ptr    = do_rd ? bump(rd_ptr) : rd_ptr;
    next_out_valid = (next_wr_ptr != next_rd_ptr);
    // A word written into an empty buffer is not in storage yet, so it bypasses it
    if (do_wr && (next_rd_ptr[AW-1:0] == wr_ptr[AW-1:0])) begin
      next_out_data = in_data_i;
    end else begin
      next_out_data = mem[next_rd_ptr[AW-1:0]];
    end
  end

  // Pointer and output registers; the read-side outputs leave straight from flops
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wr_ptr      <= '0;
      rd_ptr      <= '0;
      out_valid_o <= 1'b0;
      out_data_o  <= '0;
    end else begin
      wr_ptr      <= next_wr_ptr;
      rd_ptr      <= next_rd_ptr;
      out_valid_o <= next_out_valid;
      out_data_o  <= next_out_data;
    end
  end

  // Storage needs no reset; only written slots are ever offered with out_valid_o high
  always_ff @(posedge clk_i) begin
    if (do_wr) begin
      mem[wr_ptr[AW-1:0]] <= in_data_i;
    end
  end
endmodule

// How it works
// - Normal mode: store while busy, acknowledged or errored, and no begin strobe.
// - Multiplexed mode: store while busy and any acknowledge or begin strobe is low.
// - Every strobe term counts as true at the low level.
// - Qualifier drives status bit 15 and the auxiliary clock output.
// - Bus clock samples by default; a static select picks data latch enable.
// - The selected sampling clock goes to the first and the status probe.
// - Address, status and data reach the probes through register buffers.
// - Every sampling edge stores a state while the buffer has room; an edge on a full buffer is dropped and sets the lost flag.
// - Capture ignores cycle type: bursts, user, supervisor, grant, CPU space.
// - A high qualifier bit means the current pin state should be stored.
module bcq_capture #(
  parameter int DEPTH = bcq_pkg::FIFO_DEPTH
) (
  input  wire logic                        clk_i,
  input  wire logic                        rst_i,
  input  wire logic                        bus_clk_i,
  input  wire logic                        data_latch_enable_i,
  input  wire logic                        clk_src_i,
  input  wire logic                        mux_mode_i,
  input  wire logic [bcq_pkg::ADDR_W-1:0]  addr_i,
  input  wire logic [bcq_pkg::DATA_W-1:0]  data_i,
  input  wire logic [bcq_pkg::STAT_W-1:0]  status_i,
  input  wire logic                        smp_ready_i,
  output logic                             smp_valid_o,
  output bcq_pkg::bcq_sample_t             smp_o,
  output logic                             probe1_clk_o,
  output logic                             stat_clk_o,
  output logic                             qual_bit_o,
  output logic                             aux_clk_o,
  output logic                             lost_o
);
  bcq_pkg::bcq_pins_t   pins;
  bcq_pkg::bcq_pins_t   s1;
  bcq_pkg::bcq_pins_t   s2;
  bcq_pkg::bcq_sample_t wr_smp;
  logic                 bclk_d;
  logic                 latch_d;
  logic                 qual;
  logic                 pclk;
  logic                 lost;
  logic                 next_qual;
  logic                 next_pclk;
  logic                 next_lost;
  logic                 sel_edge;
  logic                 fifo_ready;
  logic                 push;

  // Qualifier equations, strobes active low
  function automatic logic bcq_qual(input logic [bcq_pkg::STAT_W-1:0] st,
                                    input bcq_pkg::bcq_qmode_t        m);
    logic busy;
    logic ack;
    logic start;
    busy  = !st[bcq_pkg::ST_BUSY];
    ack   = !st[bcq_pkg::ST_ACK] || !st[bcq_pkg::ST_ERR_ACK];
    start = !st[bcq_pkg::ST_BEGIN];
    if (m == bcq_pkg::BCQ_QUAL_MUX) begin
      return busy && (ack || start);
    end else begin
      return busy && ack && !start;
    end
  endfunction

  // Pin bundle, including the static jumper-like selects
  always_comb begin
    pins.bus_clk = bus_clk_i;
    pins.data_latch_enable = data_latch_enable_i;
    pins.src     = clk_src_i ? bcq_pkg::BCQ_SRC_LATCH : bcq_pkg::BCQ_SRC_BUS;
    pins.qmode   = mux_mode_i ? bcq_pkg::BCQ_QUAL_MUX : bcq_pkg::BCQ_QUAL_NORMAL;
    pins.addr    = addr_i;
    pins.data    = data_i;
    pins.status  = status_i;
  end

  // two-stage input buffer; lines and clocks share the delay
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1     <= bcq_pkg::PINS_RST;
      s2     <= bcq_pkg::PINS_RST;
      bclk_d  <= 1'b0;
      latch_d <= 1'b0;
    end else begin
      s1      <= pins;
      s2      <= s1;
      bclk_d  <= s2.bus_clk;
      latch_d <= s2.data_latch_enable;
    end
  end

  // rising edge of the selected sampling clock
  assign sel_edge = (s2.src == bcq_pkg::BCQ_SRC_LATCH) ? (s2.data_latch_enable && !latch_d)
                                                       : (s2.bus_clk && !bclk_d);

  // qualifier built from the very strobes being stored
  always_comb begin
    wr_smp.addr   = s2.addr;
    wr_smp.data   = s2.data;
    wr_smp.status = {bcq_qual(s2.status, s2.qmode), s2.status};
  end

  // a sampling edge pushes only while the buffer has room; a full buffer is flagged, never silent
  assign push = sel_edge && fifo_ready;

  // Next output state
  always_comb begin
    next_qual = bcq_qual(s2.status, s2.qmode);
    next_pclk = (s2.src == bcq_pkg::BCQ_SRC_LATCH) ? s2.data_latch_enable : s2.bus_clk;
    next_lost = lost || (sel_edge && !fifo_ready);
  end

  // Output registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      qual <= 1'b0;
      pclk <= 1'b0;
      lost <= 1'b0;
    end else begin
      qual <= next_qual;
      pclk <= next_pclk;
      lost <= next_lost;
    end
  end

  // one sampling clock to both probes
  assign probe1_clk_o = pclk;
  assign stat_clk_o   = pclk;
  // qualifier on bit 15 and the auxiliary clock
  assign qual_bit_o   = qual;
  assign aux_clk_o    = qual;
  assign lost_o       = lost;

  // Sample buffer; a slow analyzer side stalls and eventually fills it
  bcq_fifo #(
    .W     ($bits(bcq_pkg::bcq_sample_t)),
    .DEPTH (DEPTH)
  ) u_fifo (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .in_valid_i  (sel_edge),
    .in_ready_o  (fifo_ready),
    .in_data_i   (wr_smp),
    .out_valid_o (smp_valid_o),
    .out_ready_i (smp_ready_i),
    .out_data_o  (smp_o)
  );

  // Checks on the qualifier, clocking and buffering
  property p_norm_qual;
    @(posedge clk_i) disable iff (rst_i)
      (s2.qmode == bcq_pkg::BCQ_QUAL_NORMAL && !s2.status[bcq_pkg::ST_BUSY] &&
       !s2.status[bcq_pkg::ST_ACK] && s2.status[bcq_pkg::ST_BEGIN]) |=> qual_bit_o;
  endproperty
  a_norm_qual: assert property (p_norm_qual) else $error("normal qualifier missing");

  property p_norm_ts;
    @(posedge clk_i) disable iff (rst_i)
      (s2.qmode == bcq_pkg::BCQ_QUAL_NORMAL && !s2.status[bcq_pkg::ST_BEGIN])
        |=> !qual_bit_o;
  endproperty
  a_norm_ts: assert property (p_norm_ts) else $error("begin strobe qualified");

  property p_mux_qual;
    @(posedge clk_i) disable iff (rst_i)
      (s2.qmode == bcq_pkg::BCQ_QUAL_MUX && !s2.status[bcq_pkg::ST_BUSY] &&
       !s2.status[bcq_pkg::ST_BEGIN]) |=> qual_bit_o;
  endproperty
  a_mux_qual: assert property (p_mux_qual) else $error("mux qualifier missing");

  property p_idle_low;
    @(posedge clk_i) disable iff (rst_i)
      s2.status[bcq_pkg::ST_BUSY] |=> !qual_bit_o;
  endproperty
  a_idle_low: assert property (p_idle_low) else $error("qualifier high while idle");

  property p_qual_store;
    @(posedge clk_i) disable iff (rst_i)
      push |=> (qual_bit_o == $past(wr_smp.status[bcq_pkg::QUAL_BIT])) &&
               (aux_clk_o == qual_bit_o);
  endproperty
  a_qual_store: assert property (p_qual_store) else $error("stored qualifier differs");

  property p_src_bus;
    @(posedge clk_i) disable iff (rst_i)
      (s2.src == bcq_pkg::BCQ_SRC_BUS) |=> (probe1_clk_o == $past(s2.bus_clk));
  endproperty
  a_src_bus: assert property (p_src_bus) else $error("bus clock not selected");

  property p_same_clk;
    @(posedge clk_i) disable iff (rst_i)
      probe1_clk_o == stat_clk_o;
  endproperty
  a_same_clk: assert property (p_same_clk) else $error("probe clocks differ");

  property p_buffered;
    @(posedge clk_i) disable iff (rst_i)
      push && !$past(rst_i, 2) |-> (wr_smp.addr == $past(addr_i, 2)) &&
                                   (wr_smp.data == $past(data_i, 2));
  endproperty
  a_buffered: assert property (p_buffered) else $error("buffered lines stale");

  property p_no_omit;
    @(posedge clk_i) disable iff (rst_i)
      push |=> smp_valid_o;
  endproperty
  a_no_omit: assert property (p_no_omit) else $error("pushed state not offered");

  property p_same_strobes;
    @(posedge clk_i) disable iff (rst_i)
      push |-> wr_smp.status[bcq_pkg::QUAL_BIT] == bcq_qual(s2.status, s2.qmode);
  endproperty
  a_same_strobes: assert property (p_same_strobes) else $error("qualifier skewed");

  // Main scenarios
  c_norm_store: cover property (@(posedge clk_i) disable iff (rst_i)
    push && s2.qmode == bcq_pkg::BCQ_QUAL_NORMAL && wr_smp.status[bcq_pkg::QUAL_BIT]);
  c_mux_store: cover property (@(posedge clk_i) disable iff (rst_i)
    push && s2.qmode == bcq_pkg::BCQ_QUAL_MUX && wr_smp.status[bcq_pkg::QUAL_BIT]);
  c_latch_push: cover property (@(posedge clk_i) disable iff (rst_i)
    push && s2.src == bcq_pkg::BCQ_SRC_LATCH);
  c_full: cover property (@(posedge clk_i) disable iff (rst_i)
    sel_edge && !fifo_ready);
endmodule

// ---- bcq_pkg.sv ----
package bcq_pkg;
  // Probe widths and status probe layout
  localparam int ADDR_W     = 32;
  localparam int DATA_W     = 32;
  localparam int STAT_W     = 15;
  localparam int QUAL_BIT   = 15;
  localparam int ST_ACK     = 8;
  localparam int ST_ERR_ACK = 9;
  localparam int ST_BEGIN   = 10;
  localparam int ST_BUSY    = 11;
  localparam int FIFO_DEPTH = 4;

  typedef enum logic {BCQ_SRC_BUS, BCQ_SRC_LATCH} bcq_src_t;
  typedef enum logic {BCQ_QUAL_NORMAL, BCQ_QUAL_MUX} bcq_qmode_t;

  // One stored analyzer state: both probes plus the status probe
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
    logic [STAT_W:0]   status;
  } bcq_sample_t;

  // Everything that arrives on pins from the processor side
  typedef struct packed {
    logic              bus_clk;
    logic              data_latch_enable;
    bcq_src_t          src;
    bcq_qmode_t        qmode;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
    logic [STAT_W-1:0] status;
  } bcq_pins_t;

  // Strobes idle high, so the status lines reset to all ones
  localparam bcq_pins_t PINS_RST = '{bus_clk: 1'b0, data_latch_enable: 1'b0,
                                     src: BCQ_SRC_BUS, qmode: BCQ_QUAL_NORMAL,
                                     addr: '0, data: '0, status: '1};
endpackage

// ---- bcq_bus_model.sv ----
`timescale 1ns/1ps
module bcq_bus_model (
  input  wire logic                  clk_i,
  output logic                       bus_clk_o,
  output logic                       data_latch_enable_o,
  output logic [bcq_pkg::ADDR_W-1:0] addr_o,
  output logic [bcq_pkg::DATA_W-1:0] data_o,
  output logic [bcq_pkg::STAT_W-1:0] status_o
);
  // Clocks stand low between transfers; strobes idle high
  // idle no transfer
  initial begin
    bus_clk_o = 1'b0;
    data_latch_enable_o = 1'b0;
    addr_o = 32'h0;
    data_o = 32'h0;
    status_o = 15'h7FFF;
  end

  // Static strobe levels, used while no clock edge is made
  task automatic drive(input logic [14:0] st);
    @(posedge clk_i);
    status_o <= st;
  endtask

  // Lines settle eight system clock cycles before the selected clock rises
  // begin strobe pattern
  task automatic rise(input logic [31:0] a, input logic [31:0] d,
                      input logic [14:0] st, input logic use_dle);
    @(posedge clk_i);
    addr_o <= a;
    data_o <= d;
    status_o <= st;
    repeat (8) @(posedge clk_i);
    if (use_dle) begin
      data_latch_enable_o <= 1'b1;
    end else begin
      bus_clk_o <= 1'b1;
    end
  endtask

  // Released lines show the inverse so stale values never match
  // strobes released
  task automatic fall();
    repeat (8) @(posedge clk_i);
    bus_clk_o <= 1'b0;
    data_latch_enable_o <= 1'b0;
    addr_o <= ~addr_o;
    data_o <= ~data_o;
    status_o <= 15'h7FFF;
  endtask
endmodule

// ---- tb_bus_capture_qualifier.sv ----
`timescale 1ns/1ps
module tb_bus_capture_qualifier;
  logic                 clk = 1'b0;
  logic                 rst = 1'b1;
  logic                 src = 1'b0;
  logic                 multiplexed_mode = 1'b0;
  logic                 rdy = 1'b0;
  logic                 bclk, latch_en, valid, p1clk, sclk, qbit, aux, lost;
  logic [31:0]          addr, data;
  logic [14:0]          stat;
  bcq_pkg::bcq_sample_t smp;
  logic [79:0]          exp_q[$];
  logic [14:0]          pat[4] = '{15'h7601, 15'h7508, 15'h7314, 15'h661C};
  int                   num_errors = 0;
  int                   num_checks = 0;

  // 100 MHz system clock
  always #5 clk = ~clk;

  bcq_bus_model bus (.clk_i(clk), .bus_clk_o(bclk), .data_latch_enable_o(latch_en),
                     .addr_o(addr), .data_o(data), .status_o(stat));

  bcq_capture uut (.clk_i(clk), .rst_i(rst), .bus_clk_i(bclk),
                   .data_latch_enable_i(latch_en),
                   .clk_src_i(src), .mux_mode_i(multiplexed_mode), .addr_i(addr), .data_i(data),
                   .status_i(stat), .smp_ready_i(rdy), .smp_valid_o(valid), .smp_o(smp),
                   .probe1_clk_o(p1clk), .stat_clk_o(sclk), .qual_bit_o(qbit),
                   .aux_clk_o(aux), .lost_o(lost));

  task automatic close_out();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [79:0] seen, input logic [79:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Expected qualifier; every strobe counts at its low level
  // active low terms
  function automatic logic qual(input logic [14:0] s, input logic m);
    logic busy, ack, start;
    busy = !s[bcq_pkg::ST_BUSY];
    ack = !s[bcq_pkg::ST_ACK] || !s[bcq_pkg::ST_ERR_ACK];
    start = !s[bcq_pkg::ST_BEGIN];
    qual = m ? busy && (ack || start) : busy && ack && !start;
  endfunction

  task automatic do_reset();
    @(posedge clk);
    rst <= 1'b1;
    rdy <= 1'b0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
  endtask

  // All sixteen strobe levels in both qualifier forms
  task automatic t_qual();
    logic [14:0] st;
    for (int i = 0; i < 32; i++) begin
      st = {3'h7, i[3:0], 8'h00};
      @(posedge clk);
      multiplexed_mode <= i[4];
      bus.drive(st);
      repeat (6) @(posedge clk);
      #1;
      check("qual_bit", qbit, qual(st, i[4]));
      check("aux_clk", aux, qual(st, i[4]));
    end
  endtask

  // One transfer on the chosen sampling clock, ready held low
  task automatic xfer(input int k, input logic s);
    logic [31:0] a;
    a = 32'hC0DE0000 + k;
    bus.rise(a, ~a, pat[k % 4], s);
    repeat (4) @(posedge clk);
    #1;
    check("probe1_clk", p1clk, 1'b1);
    check("stat_clk", sclk, 1'b1);
    bus.fall();
    exp_q.push_back({a, ~a, qual(pat[k % 4], multiplexed_mode), pat[k % 4]});
  endtask

  // Four transfers fill the buffer without loss
  // source select
  task automatic t_capture(input logic s);
    @(posedge clk);
    src <= s;
    multiplexed_mode <= s;
    repeat (6) @(posedge clk);
    for (int k = 0; k < 4; k++) begin
      xfer(k, s);
    end
    #1;
    check("lost_full", lost, 1'b0);
  endtask

  // A fifth edge meets a full buffer and is refused
  task automatic t_overflow();
    xfer(4, src);
    void'(exp_q.pop_back());
    repeat (4) @(posedge clk);
    #1;
    check("lost_set", lost, 1'b1);
  endtask

  // Pop each stored state in order, then the buffer is empty
  // buffered lines
  task automatic t_drain();
    int n;
    while (exp_q.size() > 0) begin
      n = 0;
      while (valid !== 1'b1) begin
        @(posedge clk);
        #1;
        n++;
        if (n > 50) begin
          num_errors++;
          close_out();
        end
      end
      check("sample", smp, exp_q.pop_front());
      @(posedge clk);
      rdy <= 1'b1;
      @(posedge clk);
      rdy <= 1'b0;
      #1;
    end
    repeat (2) @(posedge clk);
    #1;
    check("empty", valid, 1'b0);
  endtask

  initial begin
    do_reset();
    t_qual();
    t_capture(1'b0);
    t_overflow();
    t_drain();
    do_reset();
    t_capture(1'b1);
    t_drain();
    close_out();
  end
endmodule
